// ### logic/isp_pkg.sv
package isp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and self-timed waits
    localparam int CLK_MHZ = 50;            // system clock rate
    localparam int FLASH_WRITE_WAIT_US = 7000;  // page program time, microseconds
    localparam int EEPROM_WRITE_WAIT_US = 700;  // eeprom byte program time
    localparam int ERASE_WAIT_US = 14000;   // chip erase time
    localparam int FLASH_WRITE_WAIT_CYC = FLASH_WRITE_WAIT_US * CLK_MHZ;
    localparam int EEPROM_WRITE_WAIT_CYC = EEPROM_WRITE_WAIT_US * CLK_MHZ;
    localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
    localparam int WAIT_W = 20;             // width of the wait counter

    ////////////////////////////////////////////////////////////////////////////////
    // address spaces
    localparam int FLASH_AW = 13;           // word address 0000..1FFF
    localparam int EE_AW = 9;               // byte address 0000..01FF
    localparam int PAGE_AW = 6;             // word position inside a page
    localparam int PAGE_NUM_W = 7;          // page number
    localparam int PAGE_WORDS = 64;
    localparam logic [FLASH_AW-1:0] FLASH_LAST = 13'h1FFF;
    localparam logic [EE_AW-1:0] EE_LAST = 9'h1FF;
    localparam logic [PAGE_AW-1:0] PAGE_LAST = 6'h3F;

    ////////////////////////////////////////////////////////////////////////////////
    // instruction encodings
    localparam logic [7:0] OP_ENABLE = 8'hAC;      // enable, erase share this
    localparam logic [7:0] ENABLE_KEY = 8'h53;     // second byte of enable
    localparam logic [2:0] ERASE_KEY = 3'h4;       // top bits of erase byte 2
    localparam logic [7:0] OP_LOAD_LO = 8'h40;
    localparam logic [7:0] OP_LOAD_HI = 8'h48;
    localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
    localparam logic [7:0] OP_READ_LO = 8'h20;
    localparam logic [7:0] OP_READ_HI = 8'h28;
    localparam logic [7:0] OP_READ_EE = 8'hA0;
    localparam logic [7:0] OP_WRITE_EE = 8'hC0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0] NO_DATA = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // framing
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] BYTE_1 = 2'h0;
    localparam logic [1:0] BYTE_2 = 2'h1;
    localparam logic [1:0] BYTE_3 = 2'h2;
    localparam logic [1:0] BYTE_4 = 2'h3;

    // self-timed write engine
    typedef enum logic [2:0] {
        ISP_IDLE = 3'b000,
        ISP_ERASE_FLASH = 3'b001,
        ISP_ERASE_EE = 3'b010,
        ISP_PAGE = 3'b011,
        ISP_EE_CLEAR = 3'b100,
        ISP_EE_WRITE = 3'b101,
        ISP_WAIT = 3'b110
    } isp_walk_e;

endpackage : isp_pkg

// ### logic/isp_wait_timer.sv
`timescale 1ns/10ps
module isp_wait_timer #(
    parameter int TW = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // start request and length
    input wire logic load,
    input wire logic [TW-1:0] count,
    // one-cycle end pulse
    output logic done
);

    typedef struct packed {
        logic [TW-1:0] cnt; // cycles left
        logic run;          // counting
        logic done;         // end pulse
    } isp_timer_s;

    isp_timer_s q;
    isp_timer_s d;

    ////////////////////////////////////////////////////////////////////////////////
    // next state: a load restarts the count even while running
    always_comb begin
        d = q;
        d.done = 1'b0;
        if (load) begin
            d.cnt = count;
            d.run = 1'b1;
        end else if (q.run) begin
            if (q.cnt <= TW'(1)) begin
                d.run = 1'b0;
                d.done = 1'b1;
            end else begin
                d.cnt = q.cnt - TW'(1);
            end
        end
    end

    // register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;

endmodule : isp_wait_timer

// ### logic/isp_port.sv
`timescale 1ns/10ps
// Function
// RULE_01 - serial access only while reset pin low
// RULE_02 - enable first; others rejected before it
// RULE_03 - eeprom byte write erases location first
// RULE_04 - chip erase fills both arrays with FF
// RULE_05 - flash words 0-1FFF, eeprom 0-01FF
// RULE_06 - programmer keeps sck phases over 2 clocks
// RULE_07 - mosi sampled on sck rising edge
// RULE_08 - miso changes on sck falling edge
// RULE_09 - power-up: reset and sck low
// RULE_10 - programmer waits 20 ms before enable; model settles only 60 clocks (POWERUP_CYC)
// RULE_11 - echo 53 during third enable byte
// RULE_12 - programmer sends all four bytes always
// RULE_13 - programmer resets after chip erase
// RULE_14 - page buffer indexed by 6 low bits
// RULE_15 - page written at 7 high bits
// RULE_16 - programmer waits flash write wait
// RULE_17 - programmer writes eeprom byte by byte
// RULE_18 - reads return addressed content on miso
// RULE_19 - reset pin high leaves programming mode
// RULE_20 - reads inside busy page return FF
// RULE_21 - programmer waits when data is FF
// RULE_22 - enable is AC 53 then two bytes
// RULE_23 - erase is AC, byte two top 100
// RULE_24 - page write 4C, page in bytes 2-3
// RULE_25 - eeprom write C0, addr, addr, data
// RULE_26 - msb first; execute after four bytes
// RULE_27 - writes ignored while self-timed op runs
module isp_port #(
    parameter int FLASH_WAIT_CYC = isp_pkg::FLASH_WRITE_WAIT_CYC,
    parameter int EEPROM_WAIT_CYC = isp_pkg::EEPROM_WRITE_WAIT_CYC,
    parameter int ERASE_CYC = isp_pkg::ERASE_WAIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link pins
    input wire logic isp_sck,
    input wire logic isp_mosi,
    input wire logic isp_reset_n,
    output logic isp_miso,
    output logic isp_miso_oe,
    // mode status
    output logic normal_op,
    output logic busy,
    // program memory array
    output logic flash_we,
    output logic [isp_pkg::FLASH_AW-1:0] flash_waddr,
    output logic [15:0] flash_wdata,
    output logic [isp_pkg::FLASH_AW-1:0] flash_raddr,
    input wire logic [15:0] flash_rdata,
    // eeprom array
    output logic ee_we,
    output logic [isp_pkg::EE_AW-1:0] ee_waddr,
    output logic [7:0] ee_wdata,
    output logic [isp_pkg::EE_AW-1:0] ee_raddr,
    input wire logic [7:0] ee_rdata
);

    localparam int TW = isp_pkg::WAIT_W;

    // refuse wait lengths the counter cannot hold
    if (FLASH_WAIT_CYC < 1 || FLASH_WAIT_CYC >= (1 << TW) || EEPROM_WAIT_CYC < 1 ||
        EEPROM_WAIT_CYC >= (1 << TW) || ERASE_CYC < 1 || ERASE_CYC >= (1 << TW)) begin : g_bad
        $error("isp_port: wait count out of range");
    end

    typedef struct packed {
        logic sck_m, sck_s, sck_p;        // sck sync stages and previous
        logic mosi_m, mosi_s;             // mosi sync stages
        logic rstn_m, rstn_s;             // reset pin sync stages
        logic prog_mode;                  // reset pin held low
        logic enabled;                    // enable accepted
        logic [2:0] bit_cnt;              // bit inside byte
        logic [1:0] byte_idx;             // byte inside instruction
        logic byte_end;                   // reload reply at next fall
        logic [7:0] rx, b1, b2, b3;       // shifter and held bytes
        logic [7:0] tx;                   // reply shifter
        logic miso, miso_oe, normal_op, busy;
        logic rd_ee, rd_hi, rd_ok;        // pending read selection
        isp_pkg::isp_walk_e walk;         // write engine
        logic [isp_pkg::FLASH_AW-1:0] idx; // walk position
        logic timer_load;
        logic [TW-1:0] timer_cnt;
        logic page_busy;
        logic [isp_pkg::PAGE_NUM_W-1:0] page_num;
        logic ee_busy;
        logic [isp_pkg::EE_AW-1:0] ee_addr;
        logic [7:0] ee_data;
        logic flash_we;
        logic [isp_pkg::FLASH_AW-1:0] flash_waddr, flash_raddr;
        logic [15:0] flash_wdata;
        logic ee_we;
        logic [isp_pkg::EE_AW-1:0] ee_waddr, ee_raddr;
        logic [7:0] ee_wdata;
        logic [isp_pkg::PAGE_WORDS-1:0][15:0] pbuf; // page buffer
    } isp_state_s;

    localparam isp_state_s ST_RESET = '{
        pbuf: {isp_pkg::PAGE_WORDS{isp_pkg::ERASED_WORD}},
        rstn_m: 1'b1, rstn_s: 1'b1, normal_op: 1'b1,
        walk: isp_pkg::ISP_IDLE, default: '0};

    isp_state_s q;
    isp_state_s d;
    logic timer_done;
    logic rise;
    logic fall;
    logic wr_ok;
    logic [7:0] full;
    logic [7:0] reply;
    logic [15:0] rd_word;
    logic [7:0] rd_byte;

    ////////////////////////////////////////////////////////////////////////////////
    // self-timed wait
    isp_wait_timer #(.TW(TW)) u_wait (
        .clk(clk),
        .rst(rst),
        .load(q.timer_load),
        .count(q.timer_cnt),
        .done(timer_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read data path, masked while its location is being programmed
    always_comb begin
        rd_word = (q.page_busy && q.flash_raddr[isp_pkg::FLASH_AW-1:isp_pkg::PAGE_AW] ==
                   q.page_num) ? isp_pkg::ERASED_WORD : flash_rdata; // RULE_20
        if (!q.rd_ok) begin
            rd_byte = isp_pkg::NO_DATA;
        end else if (q.rd_ee) begin
            rd_byte = (q.ee_busy && q.ee_raddr == q.ee_addr) ? isp_pkg::ERASED_BYTE
                                                              : ee_rdata; // RULE_20
        end else begin
            rd_byte = q.rd_hi ? rd_word[15:8] : rd_word[7:0]; // RULE_18
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        d.flash_we = 1'b0;
        d.ee_we = 1'b0;
        d.timer_load = 1'b0;
        // pins cross into the clock domain; only second stages and sck_p are read
        d.sck_m = isp_sck;
        d.sck_s = q.sck_m;
        d.sck_p = q.sck_s;
        d.mosi_m = isp_mosi;
        d.mosi_s = q.mosi_m;
        d.rstn_m = isp_reset_n;
        d.rstn_s = q.rstn_m;
        rise = q.sck_s & ~q.sck_p;
        fall = ~q.sck_s & q.sck_p;
        full = {q.rx[6:0], q.mosi_s};
        wr_ok = q.enabled && q.walk == isp_pkg::ISP_IDLE; // RULE_02 RULE_27
        reply = (q.byte_idx == isp_pkg::BYTE_4 && q.rd_ok) ? rd_byte : q.rx; // RULE_11
        d.prog_mode = ~q.rstn_s; // RULE_01
        d.normal_op = q.rstn_s; // RULE_19
        d.miso_oe = ~q.rstn_s;

        if (!q.prog_mode) begin
            // out of programming mode: drop framing and enable
            d.bit_cnt = '0; // RULE_19
            d.byte_idx = isp_pkg::BYTE_1;
            d.byte_end = 1'b0;
            d.enabled = 1'b0;
            d.rd_ok = 1'b0;
            d.tx = '0;
            d.miso = 1'b0;
        end else if (rise) begin
            // shift in msb first
            d.rx = full; // RULE_07 RULE_26
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == isp_pkg::LAST_BIT) begin
                d.byte_end = 1'b1;
                d.byte_idx = q.byte_idx + 2'h1;
                case (q.byte_idx)
                    isp_pkg::BYTE_1: begin
                        d.b1 = full;
                        d.rd_ok = 1'b0;
                    end
                    isp_pkg::BYTE_2: begin
                        d.b2 = full;
                    end
                    isp_pkg::BYTE_3: begin
                        // address complete: present it to the arrays now
                        d.b3 = full;
                        d.flash_raddr = {q.b2[4:0], full}; // RULE_05
                        d.ee_raddr = {q.b2[0], full}; // RULE_05
                        d.rd_hi = q.b1 == isp_pkg::OP_READ_HI;
                        d.rd_ee = q.b1 == isp_pkg::OP_READ_EE;
                        d.rd_ok = q.enabled && (q.b1 == isp_pkg::OP_READ_LO ||
                                  q.b1 == isp_pkg::OP_READ_HI ||
                                  q.b1 == isp_pkg::OP_READ_EE); // RULE_18
                    end
                    isp_pkg::BYTE_4: begin
                        // instruction executes only once all four bytes arrived
                        if (q.b1 == isp_pkg::OP_ENABLE && q.b2 == isp_pkg::ENABLE_KEY) begin
                            d.enabled = 1'b1; // RULE_22 RULE_26
                        end else if (q.b1 == isp_pkg::OP_ENABLE &&
                                     q.b2[7:5] == isp_pkg::ERASE_KEY && wr_ok) begin
                            d.walk = isp_pkg::ISP_ERASE_FLASH; // RULE_23
                            d.idx = '0;
                        end else if ((q.b1 == isp_pkg::OP_LOAD_LO ||
                                      q.b1 == isp_pkg::OP_LOAD_HI) && wr_ok) begin
                            if (q.b1 == isp_pkg::OP_LOAD_HI) begin
                                d.pbuf[q.b3[isp_pkg::PAGE_AW-1:0]][15:8] = full; // RULE_14
                            end else begin
                                d.pbuf[q.b3[isp_pkg::PAGE_AW-1:0]][7:0] = full; // RULE_14
                            end
                        end else if (q.b1 == isp_pkg::OP_WRITE_PAGE && wr_ok) begin
                            d.page_num = {q.b2[4:0], q.b3[7:6]}; // RULE_15 RULE_24
                            d.page_busy = 1'b1;
                            d.walk = isp_pkg::ISP_PAGE;
                            d.idx = '0;
                        end else if (q.b1 == isp_pkg::OP_WRITE_EE && wr_ok) begin
                            d.ee_addr = {q.b2[0], q.b3}; // RULE_25
                            d.ee_data = full;
                            d.ee_busy = 1'b1;
                            d.walk = isp_pkg::ISP_EE_CLEAR;
                        end
                    end
                    default: begin
                        d.rd_ok = 1'b0;
                    end
                endcase
            end
        end else if (fall) begin
            // new bit on miso; a fresh byte loads after each completed one
            if (q.byte_end) begin
                d.byte_end = 1'b0;
                d.miso = reply[7]; // RULE_08 RULE_11
                d.tx = {reply[6:0], 1'b0};
            end else begin
                d.miso = q.tx[7]; // RULE_08
                d.tx = {q.tx[6:0], 1'b0};
            end
        end

        // write engine keeps running across mode exit: arrays must not be left torn
        case (q.walk)
            isp_pkg::ISP_IDLE: begin
                d.idx = d.idx;
            end
            isp_pkg::ISP_ERASE_FLASH: begin
                d.flash_we = 1'b1;
                d.flash_waddr = q.idx;
                d.flash_wdata = isp_pkg::ERASED_WORD; // RULE_04
                d.idx = q.idx + 13'h1;
                if (q.idx == isp_pkg::FLASH_LAST) begin
                    d.walk = isp_pkg::ISP_ERASE_EE;
                    d.idx = '0;
                end
            end
            isp_pkg::ISP_ERASE_EE: begin
                d.ee_we = 1'b1;
                d.ee_waddr = q.idx[isp_pkg::EE_AW-1:0];
                d.ee_wdata = isp_pkg::ERASED_BYTE; // RULE_04
                d.idx = q.idx + 13'h1;
                if (q.idx[isp_pkg::EE_AW-1:0] == isp_pkg::EE_LAST) begin
                    d.walk = isp_pkg::ISP_WAIT;
                    d.timer_load = 1'b1;
                    d.timer_cnt = TW'(ERASE_CYC);
                end
            end
            isp_pkg::ISP_PAGE: begin
                // copy the buffer out and leave it erased for the next page
                d.flash_we = 1'b1;
                d.flash_waddr = {q.page_num, q.idx[isp_pkg::PAGE_AW-1:0]}; // RULE_15
                d.flash_wdata = q.pbuf[q.idx[isp_pkg::PAGE_AW-1:0]];
                d.pbuf[q.idx[isp_pkg::PAGE_AW-1:0]] = isp_pkg::ERASED_WORD;
                d.idx = q.idx + 13'h1;
                if (q.idx[isp_pkg::PAGE_AW-1:0] == isp_pkg::PAGE_LAST) begin
                    d.walk = isp_pkg::ISP_WAIT;
                    d.timer_load = 1'b1;
                    d.timer_cnt = TW'(FLASH_WAIT_CYC);
                end
            end
            isp_pkg::ISP_EE_CLEAR: begin
                d.ee_we = 1'b1;
                d.ee_waddr = q.ee_addr;
                d.ee_wdata = isp_pkg::ERASED_BYTE; // RULE_03
                d.walk = isp_pkg::ISP_EE_WRITE;
            end
            isp_pkg::ISP_EE_WRITE: begin
                d.ee_we = 1'b1;
                d.ee_waddr = q.ee_addr;
                d.ee_wdata = q.ee_data;
                d.walk = isp_pkg::ISP_WAIT;
                d.timer_load = 1'b1;
                d.timer_cnt = TW'(EEPROM_WAIT_CYC);
            end
            isp_pkg::ISP_WAIT: begin
                if (timer_done) begin
                    d.walk = isp_pkg::ISP_IDLE; // RULE_27
                    d.page_busy = 1'b0;
                    d.ee_busy = 1'b0;
                end
            end
            default: begin
                d.walk = isp_pkg::ISP_IDLE;
            end
        endcase
        d.busy = d.walk != isp_pkg::ISP_IDLE; // RULE_27
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= ST_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from state
    assign isp_miso = q.miso;
    assign isp_miso_oe = q.miso_oe;
    assign normal_op = q.normal_op;
    assign busy = q.busy;
    assign flash_we = q.flash_we;
    assign flash_waddr = q.flash_waddr;
    assign flash_wdata = q.flash_wdata;
    assign flash_raddr = q.flash_raddr;
    assign ee_we = q.ee_we;
    assign ee_waddr = q.ee_waddr;
    assign ee_wdata = q.ee_wdata;
    assign ee_raddr = q.ee_raddr;

endmodule : isp_port

// ### verification/isp_port_sva.sv
`timescale 1ns/10ps
// port-level checks
module isp_port_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link pins
    input wire logic isp_sck,
    input wire logic isp_reset_n,
    input wire logic isp_miso,
    input wire logic isp_miso_oe,
    // mode status
    input wire logic normal_op,
    input wire logic busy,
    // program memory array
    input wire logic flash_we,
    input wire logic [isp_pkg::FLASH_AW-1:0] flash_waddr,
    input wire logic [15:0] flash_wdata,
    // eeprom array
    input wire logic ee_we,
    input wire logic [isp_pkg::EE_AW-1:0] ee_waddr,
    input wire logic [7:0] ee_wdata
);
    ////////////////////////////////////////////////////////////////////////////////
    // one clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // five samples cover the sync path
    leave_mode_a: assert property (isp_reset_n [*5] |-> normal_op)
        else $error("mode not left");
    // no serial output outside programming mode
    quiet_miso_a: assert property (normal_op [*2] |-> !isp_miso_oe && !isp_miso)
        else $error("miso driven in normal mode");
    // self-timed work only starts from programming mode
    busy_in_mode_a: assert property ($rose(busy) |-> !normal_op)
        else $error("busy rose in normal operation");
    // output bit moves only while sck sits low after a fall
    miso_on_fall_a: assert property ($changed(isp_miso) |-> !$past(isp_sck, 2))
        else $error("miso moved off a fall");
    // a program burst begins at word zero of a page
    page_start_a: assert property ($rose(flash_we) |-> flash_waddr[5:0] == 6'h00 && busy)
        else $error("burst not at word zero");
    // words of a burst are written in rising order
    waddr_step_a: assert property (flash_we && $past(flash_we)
        |-> flash_waddr == $past(flash_waddr) + 13'h0001)
        else $error("address skipped");
    // crossing a page inside a burst is only the erase walk
    erase_fill_a: assert property (flash_we && $past(flash_we)
        && flash_waddr[12:6] != $past(flash_waddr[12:6]) |-> flash_wdata == 16'hFFFF)
        else $error("erase value wrong");
    // each eeprom burst opens with an erase of the cell
    ee_erase_first_a: assert property ($rose(ee_we) |-> ee_wdata == 8'hFF)
        else $error("no erase first");
    // the data write lands on the cell just erased
    ee_same_cell_a: assert property (ee_we && ee_wdata != 8'hFF
        |-> $past(ee_we) && ee_waddr == $past(ee_waddr))
        else $error("wrong eeprom cell");
    // array strobes only inside a self-timed operation
    write_busy_a: assert property (flash_we || ee_we |-> busy)
        else $error("array written while not busy");
endmodule : isp_port_sva

bind isp_port isp_port_sva isp_port_sva_inst (
    .clk, .rst, .isp_sck, .isp_reset_n, .isp_miso, .isp_miso_oe,
    .normal_op, .busy, .flash_we, .flash_waddr, .flash_wdata, .ee_we, .ee_waddr, .ee_wdata
);

// ### verification/isp_prog_model.sv
`timescale 1ns/10ps
// programmer side of the link
module isp_prog_model #(
    parameter int HALF_CYC = 4, // clocks per sck phase
    parameter int POWERUP_CYC = 60 // settle time, shortened
) (
    // clock
    input wire logic clk,
    // link pins
    output logic sck,
    output logic mosi,
    output logic reset_n,
    input wire logic miso
);
    ////////////////////////////////////////////////////////////////////////////////
    // power-up: reset pin and sck both low
    initial begin
        sck = 1'b0;
        mosi = 1'b1;
        reset_n = 1'b0;
    end

    // wait a number of system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // whole instruction, msb first
    task automatic xfer(input logic [31:0] ins, output logic [31:0] rep);
        for (int i = 31; i >= 0; i--) begin
            mosi <= ins[i];
            tick(HALF_CYC);
            rep[i] = miso;
            sck <= 1'b1;
            tick(HALF_CYC);
            sck <= 1'b0;
        end
        tick(HALF_CYC);
        // idle data line flips
        mosi <= ~mosi;
    endtask : xfer

    // move the reset pin and settle
    task automatic set_pin(input logic v);
        reset_n <= v;
        tick(POWERUP_CYC);
    endtask : set_pin

    // reset pin pulse
    task automatic pulse_reset();
        reset_n <= 1'b1;
        tick(8);
        set_pin(1'b0);
    endtask : pulse_reset
endmodule : isp_prog_model

// ### verification/tb.sv
`timescale 1ns/10ps
module tb;
    // clock, reset and tallies
    logic clk;
    logic rst;
    int errors;
    int checked;
    // link and status
    logic isp_sck, isp_mosi, isp_reset_n, isp_miso, isp_miso_oe, normal_op, busy;
    // array ports
    logic flash_we, ee_we;
    logic [isp_pkg::FLASH_AW-1:0] flash_waddr, flash_raddr;
    logic [isp_pkg::EE_AW-1:0] ee_waddr, ee_raddr;
    logic [15:0] flash_wdata, flash_rdata;
    logic [7:0] ee_wdata, ee_rdata;
    logic [15:0] flash_mem [0:8191];
    logic [7:0] ee_mem [0:511];
    logic [31:0] rep;

    ////////////////////////////////////////////////////////////////////////////////
    // short waits
    isp_port #(.FLASH_WAIT_CYC(2000), .EEPROM_WAIT_CYC(1000), .ERASE_CYC(300)) isp_port_inst (
        .clk, .rst, .isp_sck, .isp_mosi, .isp_reset_n, .isp_miso, .isp_miso_oe,
        .normal_op, .busy, .flash_we, .flash_waddr, .flash_wdata, .flash_raddr,
        .flash_rdata, .ee_we, .ee_waddr, .ee_wdata, .ee_raddr, .ee_rdata);
    isp_prog_model isp_prog_model_inst (
        .clk, .sck(isp_sck), .mosi(isp_mosi), .reset_n(isp_reset_n), .miso(isp_miso));

    // arrays behind the ports
    initial begin
        for (int i = 0; i < 8192; i++) flash_mem[i] = 16'(i) ^ 16'h5A5A;
        for (int i = 0; i < 512; i++) ee_mem[i] = ~8'(i);
    end
    always @(posedge clk) begin
        if (flash_we) flash_mem[flash_waddr] <= flash_wdata;
        if (ee_we) ee_mem[ee_waddr] <= ee_wdata;
    end
    assign flash_rdata = flash_mem[flash_raddr];
    assign ee_rdata = ee_mem[ee_raddr];

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // comparisons and verdict
    task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_data
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_data({15'h0000, got}, {15'h0000, exp});
    endtask : cmp_flag
    task automatic give_verdict();
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // one instruction
    task automatic send(input logic [31:0] ins);
        isp_prog_model_inst.xfer(ins, rep);
    endtask : send
    // bounded wait for idle
    task automatic wait_idle();
        int n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        cmp_flag(busy, 1'b0);
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////////////
    // write before enable is ignored
    task automatic t_locked();
        send({isp_pkg::OP_WRITE_EE, 8'h00, 8'h10, 8'h3C});
        repeat (20) @(posedge clk);
        cmp_flag(busy, 1'b0);
        cmp_data({8'h00, ee_mem[16]}, 16'h00EF);
    endtask : t_locked
    // enable echoes 53
    task automatic t_enable();
        send({isp_pkg::OP_ENABLE, isp_pkg::ENABLE_KEY, 16'h0000});
        cmp_data({8'h00, rep[15:8]}, 16'h0053);
        cmp_flag(isp_miso_oe, 1'b1);
    endtask : t_enable
    // reads at the last address of each space
    task automatic t_read();
        send({isp_pkg::OP_READ_LO, 8'h1F, 8'hFF, 8'h00});
        cmp_data({8'h00, rep[7:0]}, 16'h00A5);
        send({isp_pkg::OP_READ_HI, 8'h1F, 8'hFF, 8'h00});
        cmp_data({8'h00, rep[7:0]}, 16'h0045);
        send({isp_pkg::OP_READ_EE, 8'h01, 8'hFF, 8'h00});
        cmp_data({8'h00, rep[7:0]}, 16'h0000);
    endtask : t_read
    // eeprom byte with polling
    task automatic t_eeprom();
        send({isp_pkg::OP_WRITE_EE, 8'h01, 8'h23, 8'h5A});
        send({isp_pkg::OP_READ_EE, 8'h01, 8'h23, 8'h00});
        cmp_data({8'h00, rep[7:0]}, 16'h00FF);
        wait_idle();
        send({isp_pkg::OP_READ_EE, 8'h01, 8'h23, 8'h00});
        cmp_data({8'h00, rep[7:0]}, 16'h005A);
        cmp_data({8'h00, ee_mem[291]}, 16'h005A);
    endtask : t_eeprom
    // page load, program, poll, write while busy
    task automatic t_page();
        send({isp_pkg::OP_LOAD_LO, 8'h00, 8'hC5, 8'h34});
        send({isp_pkg::OP_LOAD_HI, 8'h00, 8'hC5, 8'h12});
        send({isp_pkg::OP_WRITE_PAGE, 8'h1F, 8'hC0, 8'h00});
        send({isp_pkg::OP_READ_HI, 8'h1F, 8'hC5, 8'h00});
        cmp_data({8'h00, rep[7:0]}, 16'h00FF);
        send({isp_pkg::OP_WRITE_EE, 8'h00, 8'h20, 8'h77});
        wait_idle();
        cmp_data(flash_mem[8133], 16'h1234);
        cmp_data(flash_mem[8128], 16'hFFFF);
        cmp_data({8'h00, ee_mem[32]}, 16'h00DF);
        send({isp_pkg::OP_READ_LO, 8'h1F, 8'hC5, 8'h00});
        cmp_data({8'h00, rep[7:0]}, 16'h0034);
    endtask : t_page
    // chip erase, then restart
    task automatic t_erase();
        send({isp_pkg::OP_ENABLE, 8'h80, 16'h0000});
        wait_idle();
        cmp_data(flash_mem[0], 16'hFFFF);
        cmp_data(flash_mem[8191], 16'hFFFF);
        cmp_data({8'h00, ee_mem[511]}, 16'h00FF);
        isp_prog_model_inst.pulse_reset();
        t_enable();
        send({isp_pkg::OP_READ_EE, 8'h01, 8'h23, 8'h00});
        cmp_data({8'h00, rep[7:0]}, 16'h00FF);
    endtask : t_erase
    // pin high: normal operation, link silent
    task automatic t_leave();
        isp_prog_model_inst.set_pin(1'b1);
        cmp_flag(normal_op, 1'b1);
        cmp_flag(isp_miso_oe, 1'b0);
        send({isp_pkg::OP_READ_HI, 8'h00, 8'h05, 8'h00});
        cmp_data(rep[15:0], 16'h0000);
    endtask : t_leave

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        errors = 0;
        checked = 0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        isp_prog_model_inst.set_pin(1'b0);
        t_locked();
        t_enable();
        t_read();
        t_eeprom();
        t_page();
        t_erase();
        t_leave();
        give_verdict();
    end
    // hang guard
    initial begin
        repeat (80000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule : tb
